// ### bench/cmpc_analog_model.sv
/*
 behavioural analog comparator core on the far side of cmpc_top.
 assumes pin levels arrive from the bench as 8-bit codes.
*/
`timescale 1ns/1ps
module cmpc_analog_model #(
    parameter logic [7:0] BANDGAP = 8'h78
) (
    input  wire logic       i_clk,
    input  wire logic       i_power_en,
    input  wire logic [2:0] i_neg_sel,
    input  wire logic       i_pos_sel,
    input  wire logic       i_hi_range,
    input  wire logic       i_lo_range,
    input  wire logic [3:0] i_step,
    // pins seen as analog levels only; their digital input path is off
    input  wire logic [7:0] i_pin [4],
    output logic            o_raw
);
    logic [7:0] ladder, plus, minus;
    logic       junk = 1'b0;
    // unpowered core gives garbage, not a tidy zero
    always @(posedge i_clk) junk <= ~junk;
    always_comb begin
        ladder = {i_hi_range, i_lo_range, i_step, 2'h2};
        plus   = i_pos_sel ? i_pin[1] : ladder;
        case (i_neg_sel)
            3'h0:    minus = i_pin[0];
            3'h1:    minus = i_pin[1];
            3'h2:    minus = BANDGAP;
            3'h3:    minus = ladder;
            3'h4:    minus = i_pin[2];
            3'h5:    minus = i_pin[3];
            default: minus = 8'h00;
        endcase
        o_raw = (i_power_en && i_neg_sel[2:1] != 2'h3) ? plus > minus : junk;
    end
endmodule : cmpc_analog_model

// ### bench/cmpc_top_sva.sv
/*
 port-level assertion checker for cmpc_top, attached by bind.
 assumes one system clock, synchronous active-high reset.
*/
`timescale 1ns/1ps
module cmpc_top_sva (
    input wire logic        I_CLK_SYS,
    input wire logic        I_RST,
    input wire logic        I_WVALID,
    input wire logic        O_WREADY,
    input wire logic        O_BVALID,
    input wire logic        I_BREADY,
    input wire logic [1:0]  O_BRESP,
    input wire logic        I_ARVALID,
    input wire logic        O_ARREADY,
    input wire logic        O_RVALID,
    input wire logic        I_RREADY,
    input wire logic [31:0] O_RDATA,
    input wire logic [3:0]  I_SECOND_TIMER_CLOCK_SEL,
    input wire logic        O_TM2_CMP_CLK,
    input wire logic        O_PORT_A_LINE0_DATA,
    input wire logic        O_PORT_A_LINE0_OE,
    input wire logic        O_WAKE,
    input wire logic        O_CMP_POWER_EN,
    input wire logic [3:0]  O_LADDER_STEP
);
    logic [2:0] wr_age_reg, wr_age_next;
    logic       dat_d1_reg, dat_d1_next;
    default clocking cb @(posedge I_CLK_SYS);
    endclocking
    default disable iff (I_RST);
    // saturating age of the last write, so config changes can be tied to it
    always_comb begin
        wr_age_next = (I_WVALID && O_WREADY) ? 3'h0 : wr_age_reg + {2'h0, wr_age_reg != 3'h7};
        dat_d1_next = O_PORT_A_LINE0_DATA;
    end
    always_ff @(posedge I_CLK_SYS) begin
        wr_age_reg <= I_RST ? 3'h7 : wr_age_next;
        dat_d1_reg <= dat_d1_next;
    end
    sequence wr_taken;
        I_WVALID && O_WREADY;
    endsequence
    sequence rd_taken;
        I_ARVALID && O_ARREADY;
    endsequence
    chk_cfg_by_write: assert property ($changed({O_CMP_POWER_EN, O_PORT_A_LINE0_OE, O_LADDER_STEP}) |-> wr_age_reg <= 3'h4)
        else $error("config output moved without a write");
    chk_off_forces_zero: assert property (!O_CMP_POWER_EN [*4] |-> !O_PORT_A_LINE0_DATA && !O_TM2_CMP_CLK)
        else $error("result not zero while comparator off");
    chk_wake_on_change: assert property (O_WAKE |-> ($changed(O_PORT_A_LINE0_DATA) || $changed(dat_d1_reg)) or ##1 $changed(O_PORT_A_LINE0_DATA))
        else $error("wake pulse without result change");
    chk_tm2_gated: assert property ((I_SECOND_TIMER_CLOCK_SEL != 4'h5) [*2] |-> !O_TM2_CMP_CLK)
        else $error("timer clock active while not selected");
    chk_tm2_follow: assert property ((I_SECOND_TIMER_CLOCK_SEL == 4'h5) [*3] |-> O_TM2_CMP_CLK == O_PORT_A_LINE0_DATA || O_TM2_CMP_CLK == dat_d1_reg)
        else $error("timer clock does not follow result");
    chk_wr_answer: assert property (wr_taken |-> ##[1:6] O_BVALID)
        else $error("write response missing");
    chk_rd_answer: assert property (rd_taken |-> ##[0:4] O_RVALID)
        else $error("read response missing");
    chk_b_hold: assert property (O_BVALID && !I_BREADY |=> O_BVALID && $stable(O_BRESP))
        else $error("write response dropped early");
    chk_r_hold: assert property (O_RVALID && !I_RREADY |=> O_RVALID && $stable(O_RDATA))
        else $error("read data dropped early");
endmodule : cmpc_top_sva
bind cmpc_top cmpc_top_sva chk (.I_CLK_SYS(I_CLK_SYS), .I_RST(I_RST), .I_WVALID(I_WVALID), .O_WREADY(O_WREADY),
    .O_BVALID(O_BVALID), .I_BREADY(I_BREADY), .O_BRESP(O_BRESP), .I_ARVALID(I_ARVALID), .O_ARREADY(O_ARREADY),
    .O_RVALID(O_RVALID), .I_RREADY(I_RREADY), .O_RDATA(O_RDATA), .I_SECOND_TIMER_CLOCK_SEL(I_SECOND_TIMER_CLOCK_SEL),
    .O_TM2_CMP_CLK(O_TM2_CMP_CLK), .O_PORT_A_LINE0_DATA(O_PORT_A_LINE0_DATA), .O_PORT_A_LINE0_OE(O_PORT_A_LINE0_OE),
    .O_WAKE(O_WAKE), .O_CMP_POWER_EN(O_CMP_POWER_EN), .O_LADDER_STEP(O_LADDER_STEP));

// ### bench/tb_cmpc_top.sv
/*
 self-checking bench for cmpc_top with the analog core model.
 assumes AXI4-Lite slave, registers at word index times four.
*/
`timescale 1ns/1ps
`include "cmpc_defs.svh"
module tb_cmpc_top;
    localparam logic [7:0] A_CTRL = `CMPC_OFS_CTRL << 2;
    localparam logic [7:0] A_SEL  = `CMPC_OFS_SEL << 2;
    logic        I_CLK_SYS, I_RST, I_AWVALID, I_WVALID, I_BREADY, I_ARVALID, I_RREADY, I_SECOND_TIMER_CLOCK, I_CMP_RAW;
    logic [7:0]  I_AWADDR, I_ARADDR, c, pin [4];
    logic [31:0] I_WDATA, O_RDATA, rd;
    logic [3:0]  I_WSTRB, I_SECOND_TIMER_CLOCK_SEL, O_LADDER_STEP;
    logic [1:0]  O_BRESP, O_RRESP;
    logic [2:0]  O_CMP_NEG_SEL;
    logic        O_AWREADY, O_WREADY, O_BVALID, O_ARREADY, O_RVALID, O_CMP_POWER_EN, O_CMP_POS_SEL, res;
    logic        O_LADDER_HI_RANGE, O_LADDER_LO_RANGE, O_PORT_A_LINE0_DATA, O_PORT_A_LINE0_OE, O_WAKE, O_TM2_CMP_CLK;
    int          bad_count, checks_done, wakes, w0;
    cmpc_top dut (.I_CLK_SYS(I_CLK_SYS), .I_RST(I_RST), .I_AWADDR(I_AWADDR), .I_AWVALID(I_AWVALID),
        .O_AWREADY(O_AWREADY), .I_WDATA(I_WDATA), .I_WSTRB(I_WSTRB), .I_WVALID(I_WVALID), .O_WREADY(O_WREADY),
        .O_BRESP(O_BRESP), .O_BVALID(O_BVALID), .I_BREADY(I_BREADY), .I_ARADDR(I_ARADDR), .I_ARVALID(I_ARVALID),
        .O_ARREADY(O_ARREADY), .O_RDATA(O_RDATA), .O_RRESP(O_RRESP), .O_RVALID(O_RVALID), .I_RREADY(I_RREADY),
        .I_CMP_RAW(I_CMP_RAW), .I_SECOND_TIMER_CLOCK(I_SECOND_TIMER_CLOCK), .I_SECOND_TIMER_CLOCK_SEL(I_SECOND_TIMER_CLOCK_SEL),
        .O_CMP_POWER_EN(O_CMP_POWER_EN), .O_CMP_NEG_SEL(O_CMP_NEG_SEL), .O_CMP_POS_SEL(O_CMP_POS_SEL),
        .O_LADDER_HI_RANGE(O_LADDER_HI_RANGE), .O_LADDER_LO_RANGE(O_LADDER_LO_RANGE), .O_LADDER_STEP(O_LADDER_STEP),
        .O_PORT_A_LINE0_DATA(O_PORT_A_LINE0_DATA), .O_PORT_A_LINE0_OE(O_PORT_A_LINE0_OE), .O_WAKE(O_WAKE),
        .O_TM2_CMP_CLK(O_TM2_CMP_CLK));
    cmpc_analog_model core (.i_clk(I_CLK_SYS), .i_power_en(O_CMP_POWER_EN), .i_neg_sel(O_CMP_NEG_SEL),
        .i_pos_sel(O_CMP_POS_SEL), .i_hi_range(O_LADDER_HI_RANGE), .i_lo_range(O_LADDER_LO_RANGE),
        .i_step(O_LADDER_STEP), .i_pin(pin), .o_raw(I_CMP_RAW));
    initial begin
        I_CLK_SYS = 1'b0;
        forever #4 I_CLK_SYS = ~I_CLK_SYS;
    end
    always @(posedge I_CLK_SYS) if (O_WAKE === 1'b1) wakes <= wakes + 1;
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
        I_AWADDR  <= a;
        I_WDATA   <= {24'($urandom), d};
        I_AWVALID <= 1'b1;
        I_WVALID  <= 1'b1;
        I_BREADY  <= 1'b1;
        do begin
            @(posedge I_CLK_SYS);
            if (O_AWREADY) I_AWVALID <= 1'b0;
            if (O_WREADY) I_WVALID <= 1'b0;
        end while (!O_BVALID || I_AWVALID && !O_AWREADY || I_WVALID && !O_WREADY);
        chk(32'(O_BRESP), 32'(er));
        I_BREADY <= 1'b0;
        @(posedge I_CLK_SYS);
    endtask : wr
    task automatic rdc(input logic [7:0] a, input logic [1:0] er);
        I_ARADDR  <= a;
        I_ARVALID <= 1'b1;
        I_RREADY  <= 1'b1;
        do begin
            @(posedge I_CLK_SYS);
            if (O_ARREADY) I_ARVALID <= 1'b0;
        end while (!O_RVALID);
        rd = O_RDATA;
        chk(32'(O_RRESP), 32'(er));
        I_RREADY <= 1'b0;
        @(posedge I_CLK_SYS);
    endtask : rdc
    task automatic stop_test;
        if (bad_count == 0 && checks_done > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : stop_test
    initial begin
        #100000;
        bad_count++;
        stop_test();
    end
    initial begin
        void'($urandom(32'h4761));
        {I_RST, I_AWVALID, I_WVALID, I_BREADY, I_ARVALID, I_RREADY, I_SECOND_TIMER_CLOCK} = 7'h40;
        {I_AWADDR, I_ARADDR, I_WDATA, I_WSTRB, I_SECOND_TIMER_CLOCK_SEL} = {48'h0, 4'h1, 4'h0};
        foreach (pin[k]) pin[k] = 8'h00;
        repeat (16) @(posedge I_CLK_SYS);
        I_RST <= 1'b0;
        @(posedge I_CLK_SYS);
        chk(32'({O_CMP_POWER_EN, O_CMP_NEG_SEL, O_CMP_POS_SEL, O_LADDER_HI_RANGE, O_LADDER_LO_RANGE}), 0);
        chk(32'({O_LADDER_STEP, O_PORT_A_LINE0_OE, O_WAKE}), 0);
        rdc(A_CTRL, 2'h0);
        chk(rd, 0);
        for (int i = 0; i < 24; i++) begin
            foreach (pin[k]) pin[k] <= 8'($urandom);
            I_SECOND_TIMER_CLOCK_SEL <= ($urandom % 2) ? 4'h5 : 4'($urandom);
            c = {2'($urandom), 1'b0, 1'($urandom), 3'($urandom % 6), 1'($urandom)};
            wr(A_CTRL, c, 2'h0);
            wr(A_SEL, {1'($urandom), 1'b0, 6'($urandom)}, 2'h0);
            repeat (4) @(posedge I_CLK_SYS);
            res = c[7] & (I_CMP_RAW ^ c[4]);
            chk(32'({O_CMP_POWER_EN, O_CMP_NEG_SEL, O_CMP_POS_SEL}), 32'({c[7], c[3:0]}));
            chk(32'({O_PORT_A_LINE0_OE, 1'b0, O_LADDER_HI_RANGE, O_LADDER_LO_RANGE, O_LADDER_STEP}),
                32'(I_WDATA[7:0] & 8'hbf));
            chk(32'({O_PORT_A_LINE0_DATA, O_TM2_CMP_CLK}), 32'({res, res & (I_SECOND_TIMER_CLOCK_SEL == 4'h5)}));
            rdc(A_CTRL, 2'h0);
            chk(rd, 32'({c[7], res, c[5:0]}));
            rdc(A_SEL, 2'h0);
            chk(rd, 0);
        end
        wr(8'h40, 8'hff, 2'h2);
        rdc(A_CTRL, 2'h0);
        chk(32'(rd[7]), 32'(c[7]));
        pin[1] <= 8'h00;
        wr(A_CTRL, 8'h87, 2'h0);
        wr(A_SEL, 8'h48, 2'h0);
        repeat (6) @(posedge I_CLK_SYS);
        for (int p = 0; p < 2; p++) begin
            w0 = wakes;
            for (int k = 0; k < 6; k++) begin
                pin[1] <= ~pin[1];
                // a change shows as a wake four edges later and is counted one edge after
                repeat (6 + $urandom % 4) @(posedge I_CLK_SYS);
            end
            chk(32'(wakes - w0), 32'(6 - 6 * p));
            wr(A_SEL, 8'h08, 2'h0);
        end
        // sampled mode: result must hold until the timer clock rises
        wr(A_CTRL, 8'ha7, 2'h0);
        I_SECOND_TIMER_CLOCK <= 1'b1;
        repeat (4) @(posedge I_CLK_SYS);
        I_SECOND_TIMER_CLOCK <= 1'b0;
        pin[1] <= 8'hff;
        repeat (6) @(posedge I_CLK_SYS);
        rdc(A_CTRL, 2'h0);
        chk(rd, 32'h0000_00a7);
        I_SECOND_TIMER_CLOCK <= 1'b1;
        repeat (6) @(posedge I_CLK_SYS);
        rdc(A_CTRL, 2'h0);
        chk(rd, 32'h0000_00e7);
        stop_test();
    end
endmodule : tb_cmpc_top

// ### rtl/cmpc_defs.svh
/*
 comparator control block: register offsets, field positions, reset values.
 assumes an AXI4-Lite slave with 32-bit words; register data sits in bits 7:0.
*/
// Functional notes
// - comparator powered only while control bit 7 is set; resets off.
// - control bit 6 reads result, 1 when plus above minus; read only.
// - control bit 5 samples result on second timer clock, else passes directly.
// - control bit 4 inverts result polarity; resets to 0.
// - control bits 3..1 pick minus input; 11x reserved.
// - control bit 0 picks plus input: ladder or port A line 4.
// - select bit 7 drives comparator output onto port A line 0.
// - select bit 6 raises wake-up on every change of result bit.
// - select bits 5 and 4 enable ladder high and low range; write only.
// - select bits 3..0 set ladder step, 0000 lowest; write only.
// - second timer may use comparator output as clock with code 0101.
`ifndef CMPC_DEFS_SVH
`define CMPC_DEFS_SVH
`define CMPC_OFS_CTRL      8'h18
`define CMPC_OFS_SEL       8'h19
`define CMPC_CTRL_EN       7
`define CMPC_CTRL_RES      6
`define CMPC_CTRL_SAMP     5
`define CMPC_CTRL_INV      4
`define CMPC_CTRL_NEG_HI   3
`define CMPC_CTRL_NEG_LO   1
`define CMPC_CTRL_POS      0
`define CMPC_SEL_OUT_EN    7
`define CMPC_SEL_WAKE_EN   6
`define CMPC_SEL_HI_RANGE  5
`define CMPC_SEL_LO_RANGE  4
`define CMPC_SEL_STEP_HI   3
`define CMPC_CTRL_RST      8'h00
`define CMPC_SEL_RST       8'h00
`define CMPC_SECOND_TIMER_CLOCK_CMP   4'h5
`define CMPC_RESP_OKAY     2'h0
`define CMPC_RESP_SLVERR   2'h2
`endif

// ### rtl/cmpc_pkg.sv
/*
 types of the comparator control block.
 assumes the defs header supplies all numbers.
*/
package cmpc_pkg;
    typedef enum logic [2:0] {
        CMPC_NEG_PORT_A_LINE3 = 3'b000,
        CMPC_NEG_PORT_A_LINE4 = 3'b001,
        CMPC_NEG_BANDGAP      = 3'b010,
        CMPC_NEG_LADDER       = 3'b011,
        CMPC_NEG_PORT_B_LINE6 = 3'b100,
        CMPC_NEG_PORT_B_LINE7 = 3'b101,
        CMPC_NEG_RSVD6        = 3'b110,
        CMPC_NEG_RSVD7        = 3'b111
    } cmpc_neg_sel_t;
    typedef enum logic [1:0] {
        CMPC_WR_IDLE = 2'b00,
        CMPC_WR_RESP = 2'b01
    } cmpc_wr_state_t;
endpackage : cmpc_pkg

// ### rtl/cmpc_sync.sv
/*
 two-stage level synchroniser; the second stage drives the output directly.
 assumes the input is asynchronous to clk.
*/
`timescale 1ns/1ps
module cmpc_sync (
    input  wire logic i_clk,
    input  wire logic i_rst,
    input  wire logic i_async,
    output logic      o_sync
);
    logic meta_reg;
    logic meta_next;
    logic sync_reg;
    logic sync_next;

    always_comb begin
        meta_next = i_async;
        sync_next = meta_reg;
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            meta_reg <= 1'b0;
            sync_reg <= 1'b0;
        end else begin
            meta_reg <= meta_next;
            sync_reg <= sync_next;
        end
    end

    assign o_sync = sync_reg;
endmodule : cmpc_sync

// ### rtl/cmpc_top.sv
/*
 comparator control and status logic with AXI4-Lite register slave.
 assumes an analog comparator core outside, a raw async result input,
 and the second timer clock arriving as a synchronous level input.
*/
`timescale 1ns/1ps
`include "cmpc_defs.svh"
module cmpc_top (
    input  wire logic        I_CLK_SYS,
    input  wire logic        I_RST,
    input  wire logic [7:0]  I_AWADDR,
    input  wire logic        I_AWVALID,
    output logic             O_AWREADY,
    input  wire logic [31:0] I_WDATA,
    input  wire logic [3:0]  I_WSTRB,
    input  wire logic        I_WVALID,
    output logic             O_WREADY,
    output logic [1:0]       O_BRESP,
    output logic             O_BVALID,
    input  wire logic        I_BREADY,
    input  wire logic [7:0]  I_ARADDR,
    input  wire logic        I_ARVALID,
    output logic             O_ARREADY,
    output logic [31:0]      O_RDATA,
    output logic [1:0]       O_RRESP,
    output logic             O_RVALID,
    input  wire logic        I_RREADY,
    input  wire logic        I_CMP_RAW,
    input  wire logic        I_SECOND_TIMER_CLOCK,
    input  wire logic [3:0]  I_SECOND_TIMER_CLOCK_SEL,
    output logic             O_CMP_POWER_EN,
    output logic [2:0]       O_CMP_NEG_SEL,
    output logic             O_CMP_POS_SEL,
    output logic             O_LADDER_HI_RANGE,
    output logic             O_LADDER_LO_RANGE,
    output logic [3:0]       O_LADDER_STEP,
    output logic             O_PORT_A_LINE0_DATA,
    output logic             O_PORT_A_LINE0_OE,
    output logic             O_WAKE,
    output logic             O_TM2_CMP_CLK
);
    // offsets are word indices; byte address is four times the index
    function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
        hit = (a[7:2] == ofs[5:0]);
    endfunction : hit

    function automatic logic is_idle(input cmpc_pkg::cmpc_wr_state_t s);
        is_idle = (s == cmpc_pkg::CMPC_WR_IDLE);
    endfunction : is_idle

    function automatic logic [7:0] merge(input logic [7:0] old, input logic [31:0] d, input logic s);
        merge = s ? d[7:0] : old;
    endfunction : merge

    // register state
    logic [7:0] ctrl_reg;
    logic [7:0] ctrl_next;
    logic [7:0] sel_reg;
    logic [7:0] sel_next;

    // write channel state
    logic        aw_have_reg;
    logic        aw_have_next;
    logic [7:0]  aw_addr_reg;
    logic [7:0]  aw_addr_next;
    logic        w_have_reg;
    logic        w_have_next;
    logic [31:0] w_data_reg;
    logic [31:0] w_data_next;
    logic        w_strb_reg;
    logic        w_strb_next;
    cmpc_pkg::cmpc_wr_state_t wr_state_reg;
    cmpc_pkg::cmpc_wr_state_t wr_state_next;
    logic [1:0]  bresp_reg;
    logic [1:0]  bresp_next;
    logic        bvalid_reg;
    logic        bvalid_next;
    logic        awready_reg;
    logic        awready_next;
    logic        wready_reg;
    logic        wready_next;

    // read channel state
    logic        rvalid_reg;
    logic        rvalid_next;
    logic [31:0] rdata_reg;
    logic [31:0] rdata_next;
    logic [1:0]  rresp_reg;
    logic [1:0]  rresp_next;
    logic        arready_reg;
    logic        arready_next;

    // result path state
    logic cmp_sync;
    logic tclk_prev_reg;
    logic tclk_prev_next;
    logic samp_reg;
    logic samp_next;
    logic res_reg;
    logic res_next;
    logic res_prev_reg;
    logic res_prev_next;
    logic wake_reg;
    logic wake_next;
    logic out_reg;
    logic out_next;
    logic oe_reg;
    logic oe_next;
    logic tm2clk_reg;
    logic tm2clk_next;
    logic res_used;

    cmpc_sync u_sync (
        .i_clk   (I_CLK_SYS),
        .i_rst   (I_RST),
        .i_async (I_CMP_RAW),
        .o_sync  (cmp_sync)
    );

    // write path: address and data taken in either order
    logic do_write;
    always_comb begin
        aw_have_next  = aw_have_reg;
        aw_addr_next  = aw_addr_reg;
        w_have_next   = w_have_reg;
        w_data_next   = w_data_reg;
        w_strb_next   = w_strb_reg;
        wr_state_next = wr_state_reg;
        bresp_next    = bresp_reg;
        ctrl_next     = ctrl_reg;
        sel_next      = sel_reg;
        do_write      = 1'b0;
        bvalid_next   = bvalid_reg;
        case (wr_state_reg)
            cmpc_pkg::CMPC_WR_IDLE: begin
                if (I_AWVALID && !aw_have_reg) begin
                    aw_have_next = 1'b1;
                    aw_addr_next = I_AWADDR;
                end
                if (I_WVALID && !w_have_reg) begin
                    w_have_next = 1'b1;
                    w_data_next = I_WDATA;
                    w_strb_next = I_WSTRB[0];
                end
                if (aw_have_reg && w_have_reg) begin
                    do_write      = 1'b1;
                    aw_have_next  = 1'b0;
                    w_have_next   = 1'b0;
                    wr_state_next = cmpc_pkg::CMPC_WR_RESP;
                    bresp_next    = `CMPC_RESP_OKAY;
                    if (hit(aw_addr_reg, `CMPC_OFS_CTRL)) begin
                        // result bit is read only, keep it out of storage
                        ctrl_next = merge(ctrl_reg, w_data_reg, w_strb_reg);
                        ctrl_next[`CMPC_CTRL_RES] = 1'b0;
                    end else if (hit(aw_addr_reg, `CMPC_OFS_SEL)) begin
                        sel_next = merge(sel_reg, w_data_reg, w_strb_reg);
                    end else begin
                        bresp_next = `CMPC_RESP_SLVERR;
                    end
                end
            end
            cmpc_pkg::CMPC_WR_RESP: begin
                if (I_BREADY) begin
                    wr_state_next = cmpc_pkg::CMPC_WR_IDLE;
                    bvalid_next   = 1'b0;
                end
            end
            default: begin
                wr_state_next = cmpc_pkg::CMPC_WR_IDLE;
                bvalid_next   = 1'b0;
            end
        endcase
        // response raised only once both halves of the write are taken
        if (do_write) begin
            bvalid_next = 1'b1;
        end
    end

    // read path; select register is write only and reads as zero
    always_comb begin
        rvalid_next = rvalid_reg;
        rdata_next  = rdata_reg;
        rresp_next  = rresp_reg;
        if (rvalid_reg) begin
            if (I_RREADY) begin
                rvalid_next = 1'b0;
            end
        end else if (I_ARVALID && arready_reg) begin
            // answer only after the address handshake, never ahead of it
            rvalid_next = 1'b1;
            rresp_next  = `CMPC_RESP_OKAY;
            rdata_next  = 32'h0000_0000;
            if (hit(I_ARADDR, `CMPC_OFS_CTRL)) begin
                rdata_next[7:0] = ctrl_reg;
                rdata_next[`CMPC_CTRL_RES] = res_reg;
            end else if (!hit(I_ARADDR, `CMPC_OFS_SEL)) begin
                rresp_next = `CMPC_RESP_SLVERR;
            end
        end
    end

    // result path: polarity, optional sampling, routing, wake-up
    always_comb begin
        tclk_prev_next = I_SECOND_TIMER_CLOCK;
        samp_next      = samp_reg;
        if (I_SECOND_TIMER_CLOCK && !tclk_prev_reg) begin
            samp_next = cmp_sync;
        end
        res_used = ctrl_reg[`CMPC_CTRL_SAMP] ? samp_reg : cmp_sync;
        // powered-down comparator reports a steady zero
        res_next = ctrl_reg[`CMPC_CTRL_EN] ? (res_used ^ ctrl_reg[`CMPC_CTRL_INV]) : 1'b0;
        res_prev_next = res_reg;
        wake_next   = sel_reg[`CMPC_SEL_WAKE_EN] && (res_reg != res_prev_reg);
        out_next    = res_reg;
        oe_next     = sel_reg[`CMPC_SEL_OUT_EN];
        tm2clk_next = (I_SECOND_TIMER_CLOCK_SEL == `CMPC_SECOND_TIMER_CLOCK_CMP) ? res_reg : 1'b0;
    end

    always_ff @(posedge I_CLK_SYS) begin
        if (I_RST) begin
            ctrl_reg      <= `CMPC_CTRL_RST;
            sel_reg       <= `CMPC_SEL_RST;
            aw_have_reg   <= 1'b0;
            aw_addr_reg   <= 8'h00;
            w_have_reg    <= 1'b0;
            w_data_reg    <= 32'h0000_0000;
            w_strb_reg    <= 1'b0;
            wr_state_reg  <= cmpc_pkg::CMPC_WR_IDLE;
            bresp_reg     <= 2'h0;
            rvalid_reg    <= 1'b0;
            rdata_reg     <= 32'h0000_0000;
            rresp_reg     <= 2'h0;
            tclk_prev_reg <= 1'b0;
            samp_reg      <= 1'b0;
            res_reg       <= 1'b0;
            res_prev_reg  <= 1'b0;
            wake_reg      <= 1'b0;
            out_reg       <= 1'b0;
            oe_reg        <= 1'b0;
            tm2clk_reg    <= 1'b0;
            bvalid_reg    <= 1'b0;
        end else begin
            ctrl_reg      <= ctrl_next;
            sel_reg       <= sel_next;
            aw_have_reg   <= aw_have_next;
            aw_addr_reg   <= aw_addr_next;
            w_have_reg    <= w_have_next;
            w_data_reg    <= w_data_next;
            w_strb_reg    <= w_strb_next;
            wr_state_reg  <= wr_state_next;
            bresp_reg     <= bresp_next;
            rvalid_reg    <= rvalid_next;
            rdata_reg     <= rdata_next;
            rresp_reg     <= rresp_next;
            tclk_prev_reg <= tclk_prev_next;
            samp_reg      <= samp_next;
            res_reg       <= res_next;
            res_prev_reg  <= res_prev_next;
            wake_reg      <= wake_next;
            out_reg       <= out_next;
            oe_reg        <= oe_next;
            tm2clk_reg    <= tm2clk_next;
            bvalid_reg    <= bvalid_next;
        end
    end

    // ready pulses last one cycle; no new address or data while a response waits
    always_comb begin
        awready_next = I_AWVALID && !aw_have_reg && !awready_reg && is_idle(wr_state_reg);
        wready_next  = I_WVALID && !w_have_reg && !wready_reg && is_idle(wr_state_reg);
        arready_next = I_ARVALID && !rvalid_reg && !arready_reg;
    end

    always_ff @(posedge I_CLK_SYS) begin
        if (I_RST) begin
            awready_reg <= 1'b0;
            wready_reg  <= 1'b0;
            arready_reg <= 1'b0;
        end else begin
            awready_reg <= awready_next;
            wready_reg  <= wready_next;
            arready_reg <= arready_next;
        end
    end

    assign O_AWREADY           = awready_reg;
    assign O_WREADY            = wready_reg;
    assign O_BVALID            = bvalid_reg;
    assign O_BRESP             = bresp_reg;
    assign O_ARREADY           = arready_reg;
    assign O_RVALID            = rvalid_reg;
    assign O_RDATA             = rdata_reg;
    assign O_RRESP             = rresp_reg;
    assign O_CMP_POWER_EN      = ctrl_reg[`CMPC_CTRL_EN];
    assign O_CMP_NEG_SEL       = ctrl_reg[`CMPC_CTRL_NEG_HI:`CMPC_CTRL_NEG_LO];
    assign O_CMP_POS_SEL       = ctrl_reg[`CMPC_CTRL_POS];
    assign O_LADDER_HI_RANGE   = sel_reg[`CMPC_SEL_HI_RANGE];
    assign O_LADDER_LO_RANGE   = sel_reg[`CMPC_SEL_LO_RANGE];
    assign O_LADDER_STEP       = sel_reg[`CMPC_SEL_STEP_HI:0];
    assign O_PORT_A_LINE0_DATA = out_reg;
    assign O_PORT_A_LINE0_OE   = oe_reg;
    assign O_WAKE              = wake_reg;
    assign O_TM2_CMP_CLK       = tm2clk_reg;
endmodule : cmpc_top
